// *** epp_pi_engine.sv ***
// Behaviour
// [R01] Unprotected namespace: pass everything unchanged
// [R02] Protected write, action clear: check passing data
// [R03] Failed check ends command with failing check
// [R04] Protected write, action set: generate and insert
// [R05] Extra metadata: info at chosen end, same size
// [R06] Compare: read processing, nothing sent to host
// [R07] Protected read, action clear: forward and check
// [R08] Protected read, action set: check, then strip
// [R09] Extra metadata: never strip on reads
// [R10] Fused commands processed as if issued alone
// [R11] Check select bit 2: compare guard to CRC
// [R12] Check select bit 1: masked application tag compare
// [R13] Check select bit 0: compare reference tag
// [R14] Seed reference tag from write or read field
// [R15] Reference tag increments per following block
// [R16] Host loads type 1 seed from address
// [R17] Type 1/2: all-ones app tag skips checks
// [R18] Type 3: both tags all-ones skip checks
// [R19] Insert computed CRC, expected tag, reference tag
// [R20] Protection type comes from namespace format
// [R21] Layout: guard, app tag, reference tag, MSB first
// [R22] CRC-16 poly 8bb7, init zero, unreflected
// [R23] Several failures: guard, then app, then reference
`timescale 1ns/1ps
`default_nettype none
`include "epp_consts.svh"

module epp_pi_engine (
  input wire logic clk,
  input wire logic rst_b,
  input wire epp_pkg::epp_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic host_in_valid,
  input wire epp_pkg::epp_beat_t host_in_beat,
  output logic host_in_ready,
  output logic host_out_valid,
  output epp_pkg::epp_beat_t host_out_beat,
  input wire logic host_out_ready,
  input wire logic media_in_valid,
  input wire epp_pkg::epp_beat_t media_in_beat,
  output logic media_in_ready,
  output logic media_out_valid,
  output epp_pkg::epp_beat_t media_out_beat,
  input wire logic media_out_ready
);

  // One data byte into the guard CRC, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      r = r[15] ? ((r << 1) ^ `EPP_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic [31:0] ns_cfg_r, cmd_r, tags_r, iref_r, eiref_r;
  logic [15:0] nblk_r;
  logic read_r, compare_r, busy_r, done_r;
  epp_pkg::epp_err_t err_r;
  epp_pkg::epp_state_t state_r;
  logic [15:0] byte_cnt_r;
  logic [15:0] blk_cnt_r;
  logic [15:0] crc_r;
  logic [31:0] ref_r;
  logic [63:0] pi_cap_r;
  logic out_valid_r;
  epp_pkg::epp_beat_t out_beat_r;
  logic ack_r;
  logic [31:0] rdat_r;

  logic wb_hit, wb_wr, start, pi_on, action, pi_first, md_extra;
  logic insert, strip, in_pi, in_pres, out_pres, cur_valid, out_space;
  logic step, chk_off, bad_guard, bad_app, bad_ref, last_blk;
  logic [2:0] chk_sel;
  logic [1:0] pi_type;
  logic [7:0] md_size;
  logic [15:0] lb_size, expected_app_tag, app_tag_mask, cap_guard, cap_app;
  logic [2:0] pi_idx;
  logic [7:0] meta_idx;
  epp_pkg::epp_beat_t cur_beat;
  logic [63:0] pi_gen;
  logic [7:0] gen_byte;
  logic [31:0] cap_ref;

  // Field views of the configuration registers
  assign pi_on = ns_cfg_r[`EPP_NS_PI_EN];
  assign pi_type = ns_cfg_r[`EPP_NS_TYPE_LSB +: 2]; // see [R20]
  assign pi_first = ns_cfg_r[`EPP_NS_PI_FIRST];
  assign md_size = ns_cfg_r[`EPP_NS_MD_LSB +: 8];
  assign lb_size = ns_cfg_r[`EPP_NS_LB_LSB +: 16];
  assign action = cmd_r[`EPP_CMD_ACTION];
  assign chk_sel = cmd_r[`EPP_CMD_CHK_LSB +: 3];
  assign expected_app_tag = tags_r[15:0];
  assign app_tag_mask = tags_r[31:16];

  // Per-command mode; each command, fused or not, decodes alone
  assign md_extra = md_size > `EPP_PI_BYTES; // see [R10]
  assign insert = pi_on & ~read_r & action; // see [R04]
  assign strip = pi_on & read_r & action & ~md_extra; // see [R08] see [R09]

  // Where the eight protection bytes sit inside the metadata
  assign meta_idx = byte_cnt_r[7:0];
  assign in_pi = pi_on & (state_r == epp_pkg::EPP_META) &
                 (pi_first ? (meta_idx < `EPP_PI_BYTES) :
                  (meta_idx >= md_size - `EPP_PI_BYTES)); // see [R05]
  assign pi_idx = pi_first ? meta_idx[2:0] :
                  3'(meta_idx - (md_size - `EPP_PI_BYTES));

  // Which side of the current byte really exists on the streams
  always_comb
  begin
    in_pres = 1'b1;
    out_pres = ~(read_r & compare_r); // see [R06]
    if (state_r == epp_pkg::EPP_META)
    begin
      if (insert & ~md_extra)
        in_pres = 1'b0; // Host sends block data only
      if (strip)
        out_pres = 1'b0;
    end
  end

  // Source and sink follow the transfer direction
  assign cur_valid = read_r ? media_in_valid : host_in_valid;
  assign cur_beat = read_r ? media_in_beat : host_in_beat;
  assign out_space = ~out_valid_r |
                     (read_r ? host_out_ready : media_out_ready);
  assign step = ((state_r == epp_pkg::EPP_DATA) |
                 (state_r == epp_pkg::EPP_META)) &
                (~in_pres | cur_valid) & (~out_pres | out_space);
  assign host_in_ready = ~read_r & step & in_pres;
  assign media_in_ready = read_r & step & in_pres;
  assign host_out_valid = out_valid_r & read_r;
  assign media_out_valid = out_valid_r & ~read_r;
  assign host_out_beat = out_beat_r;
  assign media_out_beat = out_beat_r;

  // Generated information, guard first, each field msb first
  assign pi_gen = {crc_r, expected_app_tag, ref_r}; // see [R19] see [R21]
  assign gen_byte = pi_gen[8*(7 - pi_idx) +: 8];

  // Captured information split into its three fields
  assign cap_guard = pi_cap_r[63:48]; // see [R21]
  assign cap_app = pi_cap_r[47:32];
  assign cap_ref = pi_cap_r[31:0];

  // Escape values switch off every check of the block
  assign chk_off = (pi_type == `EPP_TYPE3) ?
                   ((cap_app == `EPP_APP_ESCAPE) &
                    (cap_ref == `EPP_REF_ESCAPE)) : // see [R18]
                   (cap_app == `EPP_APP_ESCAPE); // see [R17]
  assign bad_guard = chk_sel[`EPP_CHK_GUARD] &
                     (cap_guard != crc_r); // see [R11]
  assign bad_app = chk_sel[`EPP_CHK_APP] &
                   (((cap_app ^ expected_app_tag) &
                     app_tag_mask) != 16'h0000); // see [R12]
  assign bad_ref = chk_sel[`EPP_CHK_REF] &
                   (cap_ref != ref_r); // see [R13]
  assign last_blk = (blk_cnt_r + 16'h0001) == nblk_r;

  // Wishbone decode; a start is refused while a command runs
  assign wb_hit = wb_req.cyc & wb_req.stb & ~ack_r;
  assign wb_wr = wb_hit & wb_req.we;
  assign start = wb_wr & (wb_req.adr == `EPP_OFS_CTRL) & wb_req.sel[0] &
                 wb_req.dat[`EPP_CTRL_START] & ~busy_r;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= wb_hit;
  end

  // Read data; unmapped addresses read as zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdat_r <= 32'h0000_0000;
    else if (wb_hit & ~wb_req.we)
    begin
      case (wb_req.adr)
        `EPP_OFS_CTRL: rdat_r <= {29'h0, compare_r, read_r, 1'b0};
        `EPP_OFS_NS_CFG: rdat_r <= ns_cfg_r;
        `EPP_OFS_CMD: rdat_r <= cmd_r;
        `EPP_OFS_TAGS: rdat_r <= tags_r;
        `EPP_OFS_IREF: rdat_r <= iref_r;
        `EPP_OFS_EIREF: rdat_r <= eiref_r;
        `EPP_OFS_STATUS: rdat_r <= {28'h0, 2'(err_r), done_r, busy_r};
        `EPP_OFS_NBLK: rdat_r <= {16'h0000, nblk_r};
        default: rdat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;

  // Setup registers; frozen while a command is running
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ns_cfg_r <= `EPP_NS_CFG_RST;
      cmd_r <= `EPP_CMD_RST;
      tags_r <= `EPP_TAGS_RST;
      iref_r <= 32'h0000_0000;
      eiref_r <= 32'h0000_0000;
      nblk_r <= `EPP_NBLK_RST;
    end
    else if (wb_wr & ~busy_r)
    begin
      case (wb_req.adr)
        `EPP_OFS_NS_CFG: ns_cfg_r <= lane_merge(ns_cfg_r, wb_req.dat,
                                                wb_req.sel);
        `EPP_OFS_CMD: cmd_r <= lane_merge(cmd_r, wb_req.dat, wb_req.sel);
        `EPP_OFS_TAGS: tags_r <= lane_merge(tags_r, wb_req.dat, wb_req.sel);
        `EPP_OFS_IREF: iref_r <= lane_merge(iref_r, wb_req.dat, wb_req.sel);
        `EPP_OFS_EIREF: eiref_r <= lane_merge(eiref_r, wb_req.dat,
                                              wb_req.sel);
        `EPP_OFS_NBLK: nblk_r <= 16'(lane_merge({16'h0000, nblk_r},
                                                wb_req.dat, wb_req.sel));
        default: ;
      endcase
    end
  end

  // Direction and compare flag latched at start
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      read_r <= 1'b0;
      compare_r <= 1'b0;
    end
    else if (start)
    begin
      read_r <= wb_req.dat[`EPP_CTRL_READ];
      compare_r <= wb_req.dat[`EPP_CTRL_COMPARE];
    end
  end

  // Block sequencer: data bytes, metadata bytes, then the check
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= epp_pkg::EPP_IDLE;
      byte_cnt_r <= 16'h0000;
      blk_cnt_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= epp_pkg::EPP_ERR_NONE;
    end
    else
    begin
      case (state_r)
        epp_pkg::EPP_IDLE:
        begin
          if (start)
          begin
            state_r <= epp_pkg::EPP_DATA;
            byte_cnt_r <= 16'h0000;
            blk_cnt_r <= 16'h0000;
            busy_r <= 1'b1;
            done_r <= 1'b0;
            err_r <= epp_pkg::EPP_ERR_NONE;
          end
        end
        epp_pkg::EPP_DATA:
        begin
          if (step)
          begin
            if (byte_cnt_r == lb_size - 16'h0001)
            begin
              byte_cnt_r <= 16'h0000;
              state_r <= (md_size == 8'h00) ? epp_pkg::EPP_CHECK :
                         epp_pkg::EPP_META;
            end
            else
              byte_cnt_r <= byte_cnt_r + 16'h0001;
          end
        end
        epp_pkg::EPP_META:
        begin
          if (step)
          begin
            if (meta_idx == md_size - 8'h01)
            begin
              byte_cnt_r <= 16'h0000;
              state_r <= epp_pkg::EPP_CHECK;
            end
            else
              byte_cnt_r <= byte_cnt_r + 16'h0001;
          end
        end
        epp_pkg::EPP_CHECK:
        begin
          // Inserting writes and unprotected data are never checked
          if (pi_on & ~insert & ~chk_off & (bad_guard | bad_app | bad_ref))
          begin
            state_r <= epp_pkg::EPP_IDLE; // see [R02] see [R07] see [R03]
            busy_r <= 1'b0;
            done_r <= 1'b1;
            err_r <= bad_guard ? epp_pkg::EPP_ERR_GUARD : // see [R23]
                     bad_app ? epp_pkg::EPP_ERR_APP : epp_pkg::EPP_ERR_REF;
          end
          else if (last_blk)
          begin
            state_r <= epp_pkg::EPP_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
          else
          begin
            state_r <= epp_pkg::EPP_DATA;
            blk_cnt_r <= blk_cnt_r + 16'h0001;
          end
        end
        default: state_r <= epp_pkg::EPP_IDLE;
      endcase
    end
  end

  // Reference tag seeded per direction, then one more per block
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ref_r <= 32'h0000_0000;
    else if (start)
      ref_r <= wb_req.dat[`EPP_CTRL_READ] ? // see [R14] see [R16]
               eiref_r : iref_r;
    else if (state_r == epp_pkg::EPP_CHECK)
      ref_r <= ref_r + 32'h0000_0001; // see [R15]
  end

  // Guard CRC over block data only, restarted per block
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      crc_r <= `EPP_CRC_INIT;
    else if (start | (state_r == epp_pkg::EPP_CHECK))
      crc_r <= `EPP_CRC_INIT; // see [R22]
    else if (step & (state_r == epp_pkg::EPP_DATA))
      crc_r <= crc_byte(crc_r, cur_beat.data); // see [R22]
  end

  // Capture the received information bytes as they pass
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pi_cap_r <= 64'h0000_0000_0000_0000;
    else if (step & in_pi & in_pres)
      pi_cap_r <= {pi_cap_r[55:0], cur_beat.data};
  end

  // Output byte register; pass-through unless inserting
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      out_valid_r <= 1'b0;
      out_beat_r <= '0;
    end
    else if (step & out_pres)
    begin
      out_valid_r <= 1'b1;
      out_beat_r.meta <= (state_r == epp_pkg::EPP_META);
      out_beat_r.data <= (insert & in_pi) ? gen_byte : // see [R04] see [R05]
                         cur_beat.data; // see [R01]
    end
    else if (out_space)
      out_valid_r <= 1'b0;
  end

endmodule

`default_nettype wire

// *** epp_consts.svh ***
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define EPP_OFS_CTRL 8'h00
`define EPP_OFS_NS_CFG 8'h04
`define EPP_OFS_CMD 8'h08
`define EPP_OFS_TAGS 8'h0c
`define EPP_OFS_IREF 8'h10
`define EPP_OFS_EIREF 8'h14
`define EPP_OFS_STATUS 8'h18
`define EPP_OFS_NBLK 8'h1c

// Control register fields
`define EPP_CTRL_START 0
`define EPP_CTRL_READ 1
`define EPP_CTRL_COMPARE 2

// Namespace configuration fields
`define EPP_NS_PI_EN 0
`define EPP_NS_TYPE_LSB 1
`define EPP_NS_PI_FIRST 3
`define EPP_NS_MD_LSB 8
`define EPP_NS_LB_LSB 16

// Command fields
`define EPP_CMD_ACTION 0
`define EPP_CMD_CHK_LSB 1

// Protection check select bits
`define EPP_CHK_GUARD 2
`define EPP_CHK_APP 1
`define EPP_CHK_REF 0

// Status fields
`define EPP_ST_BUSY 0
`define EPP_ST_DONE 1
`define EPP_ST_ERR_LSB 2

// Reset values
`define EPP_NS_CFG_RST 32'h0200_0000
`define EPP_CMD_RST 32'h0000_0000
`define EPP_TAGS_RST 32'hffff_0000
`define EPP_NBLK_RST 16'h0001

// Protection information geometry and coding
`define EPP_PI_BYTES 8'h08
`define EPP_CRC_POLY 16'h8bb7
`define EPP_CRC_INIT 16'h0000
`define EPP_APP_ESCAPE 16'hffff
`define EPP_REF_ESCAPE 32'hffff_ffff
`define EPP_TYPE3 2'h3

`endif

// *** epp_pkg.sv ***
`default_nettype none

package epp_pkg;

  // One byte on a stream; meta marks metadata bytes
  typedef struct packed {
    logic meta;
    logic [7:0] data;
  } epp_beat_t;

  // Wishbone classic request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } epp_wb_req_t;

  typedef enum logic [1:0] {
    EPP_IDLE,
    EPP_DATA,
    EPP_META,
    EPP_CHECK
  } epp_state_t;

  typedef enum logic [1:0] {
    EPP_ERR_NONE,
    EPP_ERR_GUARD,
    EPP_ERR_APP,
    EPP_ERR_REF
  } epp_err_t;

endpackage

`default_nettype wire

// *** epp_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

module epp_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire epp_pkg::epp_wb_req_t wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic host_in_ready,
  input wire logic host_out_valid,
  input wire epp_pkg::epp_beat_t host_out_beat,
  input wire logic host_out_ready,
  input wire logic media_in_valid,
  input wire logic media_in_ready,
  input wire logic media_out_valid,
  input wire epp_pkg::epp_beat_t media_out_beat,
  input wire logic media_out_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Bus handshake: one wait state, then a single-cycle ack
  sequence s_taken;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_timing: assert property (s_taken |=> s_answer)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_req.stb))
    else $error("ack without request");
  a_unmapped_zero: assert property
    (wb_ack_o && !wb_req.we && wb_req.adr > 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Outputs hold under stall, or a byte could be lost or duplicated
  a_media_hold: assert property
    (media_out_valid && !media_out_ready |=>
     media_out_valid && $stable(media_out_beat))
    else $error("media output changed while stalled");
  a_host_hold: assert property
    (host_out_valid && !host_out_ready |=>
     host_out_valid && $stable(host_out_beat))
    else $error("host output changed while stalled");
  a_one_way: assert property (!(host_in_ready && media_in_ready))
    else $error("both inputs ready at once");
  a_host_cause: assert property
    ($rose(host_out_valid) |-> $past(media_in_valid) && $past(media_in_ready))
    else $error("host byte without media byte");
  a_media_room: assert property
    (host_in_ready |-> !media_out_valid || media_out_ready)
    else $error("host input ready with no room");
  // Stripped bytes may be taken under a host stall, but never overwrite
  a_host_room: assert property
    (media_in_ready && media_in_valid && host_out_valid && !host_out_ready |=>
     $stable(host_out_beat))
    else $error("media byte overwrote stalled host byte");
endmodule

`default_nettype wire

// *** epp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module epp_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic stall,
  output logic tx_valid,
  output epp_pkg::epp_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire epp_pkg::epp_beat_t rx_beat,
  output logic rx_ready
);
  logic [7:0] txq[$];
  logic [8:0] rxq[$];

  // Hold each byte until taken; idle data toggles so stale bytes show
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      void'(txq.pop_front());
    if (!rst_b)
    begin
      tx_valid <= 1'b0;
      tx_beat <= '0;
    end
    else if (!tx_valid || tx_ready)
    begin
      tx_valid <= !stall && txq.size() > 0;
      tx_beat <= {1'b0, !stall && txq.size() > 0 ? txq[0] : ~tx_beat.data};
    end
    rx_ready <= rst_b && !stall;
    if (rx_valid && rx_ready)
      rxq.push_back(rx_beat);
  end
endmodule

`default_nettype wire

// *** test_end_to_end_pi_processing.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "epp_consts.svh"

module test_end_to_end_pi_processing;
  logic clk;
  logic rst_b;
  logic stall;
  epp_pkg::epp_wb_req_t wb_req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, hi_v, hi_r, ho_v, ho_r, mi_v, mi_r, mo_v, mo_r;
  epp_pkg::epp_beat_t hi_b, ho_b, mi_b, mo_b;
  int seed = 20;
  int mismatches = 0;
  int check_count = 0;

  epp_pi_engine i_epp_pi_engine (.clk(clk), .rst_b(rst_b),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .host_in_valid(hi_v), .host_in_beat(hi_b), .host_in_ready(hi_r),
    .host_out_valid(ho_v), .host_out_beat(ho_b), .host_out_ready(ho_r),
    .media_in_valid(mi_v), .media_in_beat(mi_b), .media_in_ready(mi_r),
    .media_out_valid(mo_v), .media_out_beat(mo_b),
    .media_out_ready(mo_r));
  epp_host_model i_host (.clk(clk), .rst_b(rst_b), .stall(stall),
    .tx_valid(hi_v), .tx_beat(hi_b), .tx_ready(hi_r),
    .rx_valid(ho_v), .rx_beat(ho_b), .rx_ready(ho_r));
  epp_host_model i_media (.clk(clk), .rst_b(rst_b), .stall(stall),
    .tx_valid(mi_v), .tx_beat(mi_b), .tx_ready(mi_r),
    .rx_valid(mo_v), .rx_beat(mo_b), .rx_ready(mo_r));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random back-pressure on both sides
  always @(posedge clk)
    stall <= $random(seed) % 4 == 0;

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, want);
    check_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_req <= '0;
    if (wb_ack_o !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
  endtask

  function automatic logic [15:0] crc_of(logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i])
    begin
      c = c ^ {b[i], 8'h00};
      repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ 16'h8bb7 : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // Model: data of 4 bytes, PI corrupted in last block only
  task automatic run(input logic [31:0] cfg, input logic [3:0] cmd,
    input logic [2:0] ctl, input int nb, input logic [3:0] bad,
    input logic [1:0] esc);
    logic [8:0] src[$], ex[$], got[$];
    logic [7:0] d[$];
    logic [63:0] pi, gp;
    logic [31:0] rt, st;
    logic [7:0] x, y;
    logic [1:0] err;
    int md, j, k;
    bit pe, rd, ins, strip;
    md = cfg[15:8];
    pe = cfg[0];
    rd = ctl[1];
    ins = pe && !rd && cmd[0];
    strip = pe && rd && cmd[0] && md == 8;
    rt = rd ? 32'h0000_0a00 : 32'h0000_01fe;
    for (int b = 0; b < nb; b++)
    begin
      d = {};
      repeat (4) d.push_back(8'($random(seed)));
      gp = {crc_of(d), 16'h5a3c, 32'(rt + b)};
      pi = gp;
      pi[48] ^= bad[0] && b == nb - 1;
      pi[40] ^= bad[1] && b == nb - 1;
      pi[32] ^= bad[3] && b == nb - 1;
      pi[0] ^= bad[2] && b == nb - 1;
      if (esc[0])
        pi[47:32] = 16'hffff;
      if (esc[1])
        pi[31:0] = 32'hffff_ffff;
      foreach (d[i])
      begin
        src.push_back({1'b0, d[i]});
        if (!ctl[2])
          ex.push_back({1'b0, d[i]});
      end
      for (k = 0; k < md; k++)
      begin
        j = cfg[3] ? k : k + 8 - md;
        x = 8'($random(seed));
        y = x;
        if (pe && j >= 0 && j < 8)
        begin
          x = pi[63 - 8 * j -: 8];
          y = ins ? gp[63 - 8 * j -: 8] : x;
        end
        if (!(ins && md == 8))
          src.push_back({1'b1, x});
        if (!strip && !ctl[2])
          ex.push_back({1'b1, y});
      end
    end
    err = 2'h0;
    if (pe && !ins && !(cfg[2:1] == 2'h3 ? &esc : esc[0]))
      err = bad[0] && cmd[3] ? 2'h1 : bad[1] && cmd[2] ? 2'h2 :
        bad[2] && cmd[1] ? 2'h3 : 2'h0;
    i_host.rxq.delete();
    i_media.rxq.delete();
    foreach (src[i])
      if (rd)
        i_media.txq.push_back(src[i][7:0]);
      else
        i_host.txq.push_back(src[i][7:0]);
    wb(1'b1, 8'h04, cfg, st);
    wb(1'b1, 8'h08, {28'h0, cmd}, st);
    wb(1'b1, 8'h0c, 32'hff00_5a3c, st);
    wb(1'b1, 8'h10, 32'h0000_01fe, st);
    wb(1'b1, 8'h14, 32'h0000_0a00, st);
    wb(1'b1, 8'h1c, 32'(nb), st);
    wb(1'b1, 8'h00, {29'h0, ctl}, st);
    // Setup writes while busy must be ignored
    wb(1'b1, 8'h0c, 32'h0000_0000, st);
    k = 0;
    do
    begin
      wb(1'b0, 8'h18, 32'h0, st);
      k++;
    end
    while (st[1] !== 1'b1 && k < 200);
    if (k == 200)
    begin
      mismatches++;
      complete_run();
    end
    for (k = 0; k < 99; k++)
    begin
      if (rd)
        got = i_host.rxq;
      else
        got = i_media.rxq;
      if (got.size() >= ex.size())
        break;
      @(posedge clk);
    end
    check("status", {28'h0, st[3:0]}, {28'h0, err, 2'b10});
    wb(1'b0, 8'h0c, 32'h0, st);
    check("tags held", st, 32'hff00_5a3c);
    check("count", got.size(), ex.size());
    foreach (ex[i])
      check("byte", {23'h0, got[i]}, {23'h0, ex[i]});
  endtask

  initial
  begin
    logic [31:0] st;
    rst_b = 1'b0;
    wb_req = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wb(1'b1, 8'h20, 32'h1234_5678, st);
    wb(1'b0, 8'h20, 32'h0, st);
    check("unmapped", st, 32'h0);
    wb(1'b0, 8'h04, 32'h0, st);
    check("ns_cfg", st, `EPP_NS_CFG_RST);
    wb(1'b0, 8'h0c, 32'h0, st);
    check("tags", st, `EPP_TAGS_RST);
    run(32'h0004_0200, 4'he, 3'h1, 2, 4'h7, 2'h0);
    run(32'h0004_0803, 4'hf, 3'h1, 3, 4'h0, 2'h0);
    run(32'h0004_100b, 4'hf, 3'h1, 1, 4'h7, 2'h0);
    // Every mix of corruptions, masked bit included
    for (int c = 0; c < 16; c++)
      run(32'h0004_0805, 4'he, 3'h1, 2, 4'(c), 2'h0);
    run(32'h0004_0803, 4'h8, 3'h1, 1, 4'h6, 2'h0);
    run(32'h0004_0803, 4'he, 3'h3, 3, 4'h4, 2'h0);
    run(32'h0004_0803, 4'hf, 3'h3, 2, 4'h0, 2'h0);
    run(32'h0004_1003, 4'hf, 3'h3, 2, 4'h1, 2'h0);
    run(32'h0004_0803, 4'he, 3'h7, 2, 4'h2, 2'h0);
    run(32'h0004_0803, 4'he, 3'h1, 1, 4'h1, 2'h1);
    run(32'h0004_0807, 4'he, 3'h1, 1, 4'h1, 2'h1);
    run(32'h0004_0807, 4'he, 3'h3, 1, 4'h1, 2'h3);
    complete_run();
  end
endmodule

bind epp_pi_engine epp_properties i_epp_properties (.clk(clk),
  .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .host_in_ready(host_in_ready),
  .host_out_valid(host_out_valid), .host_out_beat(host_out_beat),
  .host_out_ready(host_out_ready), .media_in_valid(media_in_valid),
  .media_in_ready(media_in_ready), .media_out_valid(media_out_valid),
  .media_out_beat(media_out_beat), .media_out_ready(media_out_ready));

`default_nettype wire
